// *** sfs_pkg.sv ***
// Package of constants and types for the SENT frame scheduler
package sfs_pkg;

  // ---------------------------------------------------------------
  // Clock and time base
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  // Unit of the internal update period, scaled by two to the exponent
  localparam int UPD_UNIT_NS = 2000;
  // Longest figure, so it rounds down
  localparam int UPD_UNIT_CYC = UPD_UNIT_NS / CLK_PERIOD_NS;
  // Least trigger low time and trigger response time (plain defaults)
  localparam int TRIG_MIN_NS = 10000;
  localparam int TRIG_MIN_CYC = (TRIG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESP_NS = 4000;
  localparam int RESP_CYC = RESP_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Frame layout in ticks
  // ---------------------------------------------------------------
  localparam logic [9:0] SYNC_TICKS = 10'h038;
  localparam logic [9:0] NIB_BASE_TICKS = 10'h00C;
  localparam logic [9:0] LOW_TICKS = 10'h004;
  localparam logic [9:0] PAUSE_MIN_TICKS = 10'h00C;
  localparam logic [9:0] PAUSE_RESTART_TICKS = 10'h300;
  localparam logic [2:0] DATA_NIBS = 3'h6;
  localparam logic [3:0] CRC_SEED = 4'h5;
  localparam logic [3:0] CRC_POLY = 4'hD;
  localparam logic [3:0] EXP_MAX = 4'h7;

  // ---------------------------------------------------------------
  // Frame schedule select codes
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_STREAM = 3'h1;
  localparam logic [2:0] MODE_SYNCED = 3'h2;
  localparam logic [2:0] MODE_TRIG_SCN = 3'h3;
  localparam logic [2:0] MODE_TRIG_EDGE = 3'h4;

  // Scheduler states, Gray along idle-sync-scn-data-pause-wait
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SYNC = 3'h1,
    ST_SCN = 3'h3,
    ST_DATA = 3'h2,
    ST_PAUSE = 3'h6,
    ST_WAIT = 3'h7
  } sfs_state_t;

  // One queued nibble; last marks the checksum nibble
  typedef struct packed {
    logic [3:0] nib;
    logic last;
  } sfs_nib_t;

  // Static configuration held by the device
  typedef struct packed {
    logic [2:0] frame_schedule_select;
    logic [3:0] update_rate_exponent;
    logic [7:0] tick_period;
    logic [3:0] status_nibble;
  } sfs_cfg_t;

endpackage : sfs_pkg

// *** sfs_fifo.sv ***
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module sfs_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Fill side
  input wire logic wr_valid_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic wr_ready_out,
  // Drain side
  output logic rd_valid_out,
  output logic [WIDTH-1:0] rd_data_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);

  // Pointer arithmetic wraps by power of two only
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("sfs_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic do_wr, do_rd;

  // Full when pointers differ only in the wrap bit
  always_comb begin
    wr_ready_out = (wp_q ^ rp_q) != {1'b1, {AW{1'b0}}};
    rd_valid_out = wp_q != rp_q;
    rd_data_out = mem_q[rp_q[AW-1:0]];
    do_wr = wr_valid_in && wr_ready_out;
    do_rd = rd_ready_in && rd_valid_out;
    wp_d = do_wr ? wp_q + 1'b1 : wp_q;
    rp_d = do_rd ? rp_q + 1'b1 : rp_q;
  end

  // Pointers and storage
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
    if (do_wr) begin
      mem_q[wp_q[AW-1:0]] <= wr_data_in;
    end
  end
endmodule : sfs_fifo
`default_nettype wire

// *** sfs_tick_gen.sv ***
// Tick strobe generator with restart for frame alignment
`timescale 1ns/10ps
`default_nettype none
module sfs_tick_gen (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Control
  input wire logic restart_in,
  input wire logic [7:0] period_in,
  // Strobe
  output logic tick_out
);
  logic [7:0] cnt_q, cnt_d;
  logic tick_q, tick_d;

  // Period of zero behaves as one clock per tick
  always_comb begin
    cnt_d = cnt_q + 8'h01;
    tick_d = 1'b0;
    if (restart_in) begin
      cnt_d = 8'h00;
    end else if (cnt_q + 8'h01 >= period_in) begin
      cnt_d = 8'h00;
      tick_d = 1'b1;
    end
  end

  // Counter registers
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_out = tick_q;
endmodule : sfs_tick_gen
`default_nettype wire

// *** sfs_scheduler.sv ***
// SENT frame scheduler: streaming, synchronized and host-triggered modes
//
// Summary of operation
// (R1) Mode 001: back-to-back frames, no pause
// (R2) Streaming: capture angle at end of status nibble
// (R3) Streaming: capture age within update period bound
// (R4) Streaming: same angle may repeat across frames
// (R5) Mode 010: pause until fresh angle available
// (R6) Synchronized: sample one tick into sync
// (R7) Pause at least 12 ticks, restarts at 768
// (R8) Host pulls line low during pause
// (R9) Host releases after hold delay; frame starts
// (R10) Mode 011: latch at end of status nibble
// (R11) Mode 011: age within bound plus response
// (R12) Mode 100: latch on detected falling edge
// (R13) Host triggers all, releases each individually
// (R14) Mode 100: age variation within same bound
// (R15) Host holds low at least minimum time
// (R16) Triggered idle: release line, watch for low
`timescale 1ns/10ps
`default_nettype none
module sfs_scheduler #(
  parameter int TRIG_MIN_CYC = sfs_pkg::TRIG_MIN_CYC,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Configuration
  input wire sfs_pkg::sfs_cfg_t cfg_in,
  // Angle updates from the signal path
  input wire logic angle_valid_in,
  input wire logic [11:0] angle_in,
  // Open-drain output line
  input wire logic line_in,
  output logic line_out,
  output logic line_oe_out,
  // Status
  output logic frame_active_out,
  output logic sample_taken_out,
  output logic [11:0] sample_angle_out
);
  // Fewer than seven entries could not hold one frame's nibbles
  if (FIFO_DEPTH < 8 || TRIG_MIN_CYC < 1 || TRIG_MIN_CYC > 65535) begin : g_bad_param
    $error("sfs_scheduler parameter out of range");
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  sfs_pkg::sfs_state_t state_q, state_d;
  logic [9:0] tcnt_q, tcnt_d;
  logic tick, restart, cap, nib_end, pop;
  logic [9:0] nib_len;
  logic [2:0] mode;
  logic trig_mode;
  logic line_s1_q, line_s2_q, line_s3_q;
  logic low_edge, release_edge;
  logic [15:0] low_cnt_q, low_cnt_d;
  logic [15:0] age_q, age_d;
  logic fresh_q, fresh_d;
  logic [11:0] live_q, live_d;
  logic [7:0] fcnt_q, fcnt_d;
  logic [2:0] bcnt_q, bcnt_d;
  logic [23:0] bsh_q, bsh_d;
  logic [3:0] crc_q, crc_d;
  sfs_pkg::sfs_nib_t push_nib, head_nib;
  logic push_valid, push_ready, head_valid;
  logic oe_q, oe_d;
  logic act_q, act_d;
  logic st_q, st_d;
  logic [11:0] sa_q, sa_d;

  assign mode = cfg_in.frame_schedule_select;
  assign trig_mode = (mode == sfs_pkg::MODE_TRIG_SCN) || (mode == sfs_pkg::MODE_TRIG_EDGE);

  // ---------------------------------------------------------------
  // Tick base and nibble queue
  // ---------------------------------------------------------------
  sfs_tick_gen u_tick (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .restart_in(restart),
    .period_in(cfg_in.tick_period),
    .tick_out(tick)
  );

  sfs_fifo #(
    .WIDTH($bits(sfs_pkg::sfs_nib_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .wr_valid_in(push_valid),
    .wr_data_in(push_nib),
    .wr_ready_out(push_ready),
    .rd_valid_out(head_valid),
    .rd_data_out(head_nib),
    .rd_ready_in(pop)
  );

  // ---------------------------------------------------------------
  // Line input synchroniser
  // ---------------------------------------------------------------
  // Only the second and third stages feed edge logic
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      line_s1_q <= 1'b1;
      line_s2_q <= 1'b1;
      line_s3_q <= 1'b1;
    end else begin
      line_s1_q <= line_in;
      line_s2_q <= line_s1_q;
      line_s3_q <= line_s2_q;
    end
  end

  // Edges of the host low pulse, and its duration in clocks
  always_comb begin
    low_edge = line_s3_q && !line_s2_q; // R16
    release_edge = !line_s3_q && line_s2_q;
    low_cnt_d = low_cnt_q;
    if (line_s2_q) begin
      low_cnt_d = 16'h0000;
    end else if (low_cnt_q != 16'hFFFF) begin
      low_cnt_d = low_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      low_cnt_q <= 16'h0000;
    end else begin
      low_cnt_q <= low_cnt_d;
    end
  end

  // ---------------------------------------------------------------
  // Live angle, freshness and age
  // ---------------------------------------------------------------
  // A new update in the capture cycle keeps the fresh flag set
  always_comb begin
    live_d = angle_valid_in ? angle_in : live_q;
    fresh_d = angle_valid_in || (fresh_q && !cap); // R5
    age_d = angle_valid_in ? 16'h0000 : (age_q == 16'hFFFF ? age_q : age_q + 16'h0001);
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      live_q <= 12'h000;
      fresh_q <= 1'b0;
      age_q <= 16'h0000;
    end else begin
      live_q <= live_d;
      fresh_q <= fresh_d;
      age_q <= age_d;
    end
  end

  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------
  // Length in ticks of the pulse now being sent
  always_comb begin
    unique case (state_q)
      sfs_pkg::ST_SYNC: nib_len = sfs_pkg::SYNC_TICKS;
      sfs_pkg::ST_SCN: nib_len = sfs_pkg::NIB_BASE_TICKS + {6'h00, cfg_in.status_nibble};
      sfs_pkg::ST_DATA: nib_len = sfs_pkg::NIB_BASE_TICKS + {6'h00, head_nib.nib};
      default: nib_len = sfs_pkg::PAUSE_RESTART_TICKS;
    endcase
    nib_end = tick && (tcnt_q == nib_len - 10'h001);
  end

  // Next state, tick position and capture strobe
  always_comb begin
    state_d = state_q;
    tcnt_d = tick ? tcnt_q + 10'h001 : tcnt_q;
    cap = 1'b0;
    restart = 1'b0;
    pop = 1'b0;
    unique case (state_q)
      sfs_pkg::ST_IDLE: begin
        tcnt_d = 10'h000;
        if (mode == sfs_pkg::MODE_STREAM || mode == sfs_pkg::MODE_SYNCED) begin
          state_d = sfs_pkg::ST_SYNC;
          restart = 1'b1;
        end else if (trig_mode) begin
          state_d = sfs_pkg::ST_PAUSE;
          restart = 1'b1;
        end
      end
      sfs_pkg::ST_SYNC: begin
        if (mode == sfs_pkg::MODE_SYNCED && tick && tcnt_q == 10'h000) begin
          cap = 1'b1; // R6
        end
        if (nib_end) begin
          state_d = sfs_pkg::ST_SCN;
          tcnt_d = 10'h000;
        end
      end
      sfs_pkg::ST_SCN: begin
        if (nib_end) begin
          // Stream reuses the live value even if unchanged
          cap = (mode == sfs_pkg::MODE_STREAM) || (mode == sfs_pkg::MODE_TRIG_SCN); // R2 R3 R4 R10 R11
          state_d = sfs_pkg::ST_DATA;
          tcnt_d = 10'h000;
        end
      end
      sfs_pkg::ST_DATA: begin
        if (nib_end) begin
          pop = 1'b1;
          tcnt_d = 10'h000;
          if (head_nib.last) begin
            if (mode == sfs_pkg::MODE_STREAM) begin
              state_d = sfs_pkg::ST_SYNC; // R1
            end else if (mode == sfs_pkg::MODE_SYNCED || trig_mode) begin
              state_d = sfs_pkg::ST_PAUSE;
            end else begin
              state_d = sfs_pkg::ST_IDLE;
            end
          end
        end
      end
      sfs_pkg::ST_PAUSE: begin
        if (trig_mode) begin
          if (tick && tcnt_q == sfs_pkg::LOW_TICKS - 10'h001) begin
            state_d = sfs_pkg::ST_WAIT;
            tcnt_d = 10'h000;
          end
        end else if (mode == sfs_pkg::MODE_SYNCED) begin
          if (tick && tcnt_q + 10'h001 >= sfs_pkg::PAUSE_MIN_TICKS && fresh_q) begin
            state_d = sfs_pkg::ST_SYNC; // R5 R7
            tcnt_d = 10'h000;
          end else if (tick && tcnt_q == sfs_pkg::PAUSE_RESTART_TICKS - 10'h001) begin
            tcnt_d = 10'h000; // R7
          end
        end else begin
          state_d = sfs_pkg::ST_IDLE;
        end
      end
      sfs_pkg::ST_WAIT: begin
        tcnt_d = 10'h000;
        if (mode == sfs_pkg::MODE_TRIG_EDGE && low_edge) begin
          cap = 1'b1; // R12 R14
        end
        if (!trig_mode) begin
          state_d = sfs_pkg::ST_IDLE;
        end else if (release_edge && low_cnt_q >= 16'(TRIG_MIN_CYC)) begin
          state_d = sfs_pkg::ST_SYNC; // R9 R15
          restart = 1'b1;
        end
      end
      default: begin
        state_d = sfs_pkg::ST_IDLE;
        tcnt_d = 10'h000;
      end
    endcase
  end

  // Line drive: each pulse starts with its low phase
  always_comb begin
    oe_d = (state_d != sfs_pkg::ST_IDLE) && (state_d != sfs_pkg::ST_WAIT)
      && (tcnt_d < sfs_pkg::LOW_TICKS); // R16
    act_d = (state_d != sfs_pkg::ST_IDLE) && (state_d != sfs_pkg::ST_PAUSE)
      && (state_d != sfs_pkg::ST_WAIT);
    st_d = cap;
    sa_d = cap ? live_q : sa_q;
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_q <= sfs_pkg::ST_IDLE;
      tcnt_q <= 10'h000;
      oe_q <= 1'b0;
      act_q <= 1'b0;
      st_q <= 1'b0;
      sa_q <= 12'h000;
    end else begin
      state_q <= state_d;
      tcnt_q <= tcnt_d;
      oe_q <= oe_d;
      act_q <= act_d;
      st_q <= st_d;
      sa_q <= sa_d;
    end
  end

  // ---------------------------------------------------------------
  // Frame builder: six data nibbles then checksum into the queue
  // ---------------------------------------------------------------
  // Queue back-pressure stalls the builder, never drops nibbles
  always_comb begin
    bcnt_d = bcnt_q;
    bsh_d = bsh_q;
    crc_d = crc_q;
    fcnt_d = fcnt_q;
    push_valid = bcnt_q != 3'h0;
    push_nib.nib = (bcnt_q == 3'h1) ? crc_q : bsh_q[23:20];
    push_nib.last = bcnt_q == 3'h1;
    if (cap) begin
      bsh_d = {live_q, fcnt_q, ~live_q[11:8]};
      bcnt_d = sfs_pkg::DATA_NIBS + 3'h1;
      crc_d = sfs_pkg::CRC_SEED;
      fcnt_d = fcnt_q + 8'h01;
    end else if (push_valid && push_ready) begin
      bcnt_d = bcnt_q - 3'h1;
      if (bcnt_q != 3'h1) begin
        bsh_d = {bsh_q[19:0], 4'h0};
        crc_d = crc_step(crc_q, bsh_q[23:20]);
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      bcnt_q <= 3'h0;
      bsh_q <= 24'h000000;
      crc_q <= sfs_pkg::CRC_SEED;
      fcnt_q <= 8'h00;
    end else begin
      bcnt_q <= bcnt_d;
      bsh_q <= bsh_d;
      crc_q <= crc_d;
      fcnt_q <= fcnt_d;
    end
  end

  // Bit-serial 4-bit checksum over one nibble, MSB first
  function automatic logic [3:0] crc_step(input logic [3:0] c, input logic [3:0] n);
    logic [3:0] r;
    logic fb;
    r = c;
    for (int i = 3; i >= 0; i--) begin
      fb = r[3] ^ n[i];
      r = {r[2:0], 1'b0} ^ (fb ? sfs_pkg::CRC_POLY : 4'h0);
    end
    return r;
  endfunction : crc_step

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Open drain: the driven level is always low
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      line_out <= 1'b0;
    end else begin
      line_out <= 1'b0;
    end
  end
  assign line_oe_out = oe_q;
  assign frame_active_out = act_q;
  assign sample_taken_out = st_q;
  assign sample_angle_out = sa_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_stream_no_pause;
    @(posedge clk_sys_in) disable iff (reset_in)
    (state_q == sfs_pkg::ST_DATA && nib_end && head_nib.last && mode == sfs_pkg::MODE_STREAM)
      |=> (state_q == sfs_pkg::ST_SYNC) && oe_q;
  endproperty
  a_stream_no_pause: assert property (p_stream_no_pause) else $error("stream paused"); // R1

  property p_scn_capture;
    @(posedge clk_sys_in) disable iff (reset_in)
    (cap && (mode == sfs_pkg::MODE_STREAM || mode == sfs_pkg::MODE_TRIG_SCN))
      |-> state_q == sfs_pkg::ST_SCN && nib_end ##1 st_q && sa_q == $past(live_q);
  endproperty
  a_scn_capture: assert property (p_scn_capture) else $error("capture off SCN end"); // R2 R10

  property p_stream_age;
    @(posedge clk_sys_in) disable iff (reset_in)
    (cap && mode == sfs_pkg::MODE_STREAM && cfg_in.update_rate_exponent <= sfs_pkg::EXP_MAX)
      |-> 32'(age_q) <= (32'(sfs_pkg::UPD_UNIT_CYC) << cfg_in.update_rate_exponent);
  endproperty
  a_stream_age: assert property (p_stream_age) else $error("stream sample too old"); // R3

  property p_sync_waits_fresh;
    @(posedge clk_sys_in) disable iff (reset_in)
    (state_q == sfs_pkg::ST_PAUSE && mode == sfs_pkg::MODE_SYNCED && !fresh_q)
      |=> state_q != sfs_pkg::ST_SYNC;
  endproperty
  a_sync_waits_fresh: assert property (p_sync_waits_fresh) else $error("stale sync"); // R5

  property p_sync_sample;
    @(posedge clk_sys_in) disable iff (reset_in)
    (cap && mode == sfs_pkg::MODE_SYNCED)
      |-> state_q == sfs_pkg::ST_SYNC && tick && tcnt_q == 10'h000;
  endproperty
  a_sync_sample: assert property (p_sync_sample) else $error("sync sample point"); // R6

  property p_pause_restart;
    @(posedge clk_sys_in) disable iff (reset_in)
    (state_q == sfs_pkg::ST_PAUSE && mode == sfs_pkg::MODE_SYNCED && tick
      && tcnt_q == sfs_pkg::PAUSE_RESTART_TICKS - 10'h001 && !fresh_q)
      |=> tcnt_q == 10'h000 && oe_q;
  endproperty
  a_pause_restart: assert property (p_pause_restart) else $error("pause not restarted"); // R7

  property p_pause_min;
    @(posedge clk_sys_in) disable iff (reset_in)
    (state_q == sfs_pkg::ST_PAUSE && state_d == sfs_pkg::ST_SYNC)
      |-> tcnt_q + 10'h001 >= sfs_pkg::PAUSE_MIN_TICKS;
  endproperty
  a_pause_min: assert property (p_pause_min) else $error("pause too short"); // R7

  property p_trigger_release;
    @(posedge clk_sys_in) disable iff (reset_in)
    (state_q == sfs_pkg::ST_WAIT && trig_mode && release_edge
      && low_cnt_q >= 16'(TRIG_MIN_CYC))
      |=> state_q == sfs_pkg::ST_SYNC ##1 oe_q;
  endproperty
  a_trigger_release: assert property (p_trigger_release) else $error("no frame after release"); // R9

  property p_edge_latch;
    @(posedge clk_sys_in) disable iff (reset_in)
    (state_q == sfs_pkg::ST_WAIT && mode == sfs_pkg::MODE_TRIG_EDGE && low_edge)
      |=> st_q && sa_q == $past(live_q);
  endproperty
  a_edge_latch: assert property (p_edge_latch) else $error("no latch on low edge"); // R12

  property p_trig_age;
    @(posedge clk_sys_in) disable iff (reset_in)
    (cap && trig_mode && cfg_in.update_rate_exponent <= sfs_pkg::EXP_MAX)
      |-> 32'(age_q) <= (32'(sfs_pkg::UPD_UNIT_CYC) << cfg_in.update_rate_exponent)
        + 32'(sfs_pkg::UPD_UNIT_CYC) + 32'(sfs_pkg::RESP_CYC);
  endproperty
  a_trig_age: assert property (p_trig_age) else $error("triggered sample too old"); // R11 R14

  property p_wait_released;
    @(posedge clk_sys_in) disable iff (reset_in)
    (state_q == sfs_pkg::ST_WAIT) |-> !oe_q && !act_q;
  endproperty
  a_wait_released: assert property (p_wait_released) else $error("line driven in wait"); // R16

endmodule : sfs_scheduler
`default_nettype wire

// *** sfs_ecu_model.sv ***
// Engine control unit model: line pull-up and trigger source
`timescale 1ns/10ps
`default_nettype none
module sfs_ecu_model (
  // Clock
  input wire logic clk_sys_in,
  // Device drive
  input wire logic dev_oe_in,
  // Shared line
  output logic line_out
);
  logic host_oe_q = 1'b0;
  // Pull-up wins unless a party pulls low
  assign line_out = ~(dev_oe_in | host_oe_q);
  // ---------------------------------------------------------------
  // Trigger: wait for a released pause, then hold the line low
  // ---------------------------------------------------------------
  task automatic trigger(input int trigger_hold_delay);
    int quiet;
    quiet = 0;
    // Sync highs last 52 ticks, so 60 quiet cycles can only be a pause
    while (quiet < 60) begin
      @(posedge clk_sys_in);
      quiet = line_out ? quiet + 1 : 0;
    end
    host_oe_q <= 1'b1;
    repeat (trigger_hold_delay) @(posedge clk_sys_in);
    host_oe_q <= 1'b0;
  endtask : trigger
endmodule : sfs_ecu_model
`default_nettype wire

// *** tb_top.sv ***
// Self-checking testbench for the SENT frame scheduler
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int TRIG_MIN = 8;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  sfs_pkg::sfs_cfg_t cfg = '0;
  logic angle_valid = 1'b0;
  logic [11:0] angle = 12'h000;
  logic line, line_o, line_oe, active, taken;
  logic [11:0] smp, last_exp;
  logic [11:0] exp_q[$];
  logic have_exp = 1'b0;
  int err_total = 0;
  int checks_done = 0;
  int hi, rises;
  always #20 clk_sys_in = ~clk_sys_in;
  sfs_scheduler #(.TRIG_MIN_CYC(TRIG_MIN)) dut_u (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .cfg_in(cfg), .angle_valid_in(angle_valid), .angle_in(angle),
    .line_in(line), .line_out(line_o), .line_oe_out(line_oe), .frame_active_out(active),
    .sample_taken_out(taken), .sample_angle_out(smp));
  sfs_ecu_model ecu_u (.clk_sys_in(clk_sys_in), .dev_oe_in(line_oe), .line_out(line));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // Config must settle while reset is held
  // Top exponent: the sparse bench updates must stay inside the age bound
  task automatic restart(input logic [2:0] mode);
    @(posedge clk_sys_in);
    cfg <= {mode, 4'h7, 8'h01, 4'hA};
    reset_in <= 1'b1;
    exp_q.delete();
    have_exp = 1'b0;
    repeat (3) @(posedge clk_sys_in);
    reset_in <= 1'b0;
  endtask : restart
  // One update pulse; noted only when the next capture must show it
  task automatic send_angle(input logic [11:0] v, input bit note);
    @(posedge clk_sys_in);
    angle <= v;
    angle_valid <= 1'b1;
    if (note) exp_q.push_back(v);
    @(posedge clk_sys_in);
    angle_valid <= 1'b0;
  endtask : send_angle
  // Bounded wait on a level, sampled away from the launching edge
  task automatic wait_for(ref logic sig, input logic lvl, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys_in);
      n++;
    end while (sig !== lvl && n < lim);
    check({11'h000, sig}, {11'h000, lvl});
  endtask : wait_for
  // Count frame-active cycles and device drive rises over a window
  task automatic watch(input int n);
    logic prev;
    hi = 0;
    rises = 0;
    prev = line_oe;
    repeat (n) begin
      @(negedge clk_sys_in);
      if (active !== 1'b0) hi++;
      if (line_oe === 1'b1 && prev !== 1'b1) rises++;
      prev = line_oe;
    end
  endtask : watch
  // ---------------------------------------------------------------
  // Result watcher: a repeat capture must show the last noted angle
  // ---------------------------------------------------------------
  // Falling edge: a note pushed at the next rising edge cannot be taken early
  always @(negedge clk_sys_in) begin
    if (taken === 1'b1) begin
      if (exp_q.size() > 0) begin
        last_exp = exp_q.pop_front();
        have_exp = 1'b1;
      end
      if (have_exp) check(smp, last_exp);
    end
  end
  // Watchdog: the whole run needs well under 20000 cycles
  initial begin
    #(40 * 40000);
    err_total++;
    stop_test();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(14));
    // Streaming: update right after a capture so the next one must see it
    restart(3'h1);
    wait_for(taken, 1'b1, 2000);
    repeat (3) begin
      send_angle($urandom & 12'hFFF, 1'b1);
      wait_for(taken, 1'b1, 2000);
    end
    wait_for(taken, 1'b0, 4);
    wait_for(taken, 1'b1, 2000);
    watch(1500);
    check(hi[11:0], 12'h5DC);
    // Synchronized: no fresh data keeps pausing, restart at 768 ticks
    restart(3'h2);
    wait_for(taken, 1'b1, 2000);
    wait_for(active, 1'b0, 2000);
    wait_for(line_oe, 1'b0, 100);
    watch(1000);
    check(hi[11:0], 12'h000);
    check(rises[11:0], 12'h001);
    send_angle($urandom & 12'hFFF, 1'b1);
    wait_for(taken, 1'b1, 2000);
    // Triggered, latch at status nibble end; short low refused
    restart(3'h3);
    send_angle($urandom & 12'hFFF, 1'b0);
    ecu_u.trigger(3);
    watch(200);
    check(hi[11:0], 12'h000);
    ecu_u.trigger(TRIG_MIN + 4);
    wait_for(active, 1'b1, 40);
    send_angle($urandom & 12'hFFF, 1'b1);
    wait_for(taken, 1'b1, 500);
    // Triggered, latch on the falling edge while the line is low
    restart(3'h4);
    send_angle($urandom & 12'hFFF, 1'b1);
    fork
      ecu_u.trigger(16);
      begin
        wait_for(taken, 1'b1, 300);
        check({11'h000, line}, 12'h000);
        send_angle($urandom & 12'hFFF, 1'b0);
      end
    join
    wait_for(active, 1'b1, 40);
    wait_for(active, 1'b0, 2000);
    // Shared-bus codes are left out here: line stays released
    restart(3'h5);
    watch(400);
    check(hi[11:0] + rises[11:0], 12'h000);
    check({11'h000, line_o}, 12'h000);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
